// File: mic_core.sv
`include "mic_regs.svh"

module mic_core
    import mic_pkg::*;
#(
    parameter int ADDR_W = 18
)
(
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire logic [4:1]      request_pin_n,
    input  wire logic [7:0]      wakeup_input_n,
    input  wire logic            decoder_line_n,
    input  wire logic            converter_trigger_pin,
    input  wire logic            timer_f_event_pin,
    input  wire logic            timer_c_event_pin,
    input  wire mic_periph_evt_t periph_evt,
    input  wire logic            cpu_global_mask,
    output mic_cpu_req_t         cpu_req,
    output logic                 converter_trigger_evt,
    output logic                 timer_f_evt,
    output logic                 timer_c_evt
);

    ////////////////////////////////////////////////////////////////////////////
    // Constants and checks

    localparam int PIN_W = 15;

    localparam mic_state_t RST_ST = '{
        req_edge:   `MIC_REQ_EDGE_W'(`MIC_RST_REQ_EDGE),
        wake_edge:  `MIC_RST_WAKE_EDGE,
        en_one:     `MIC_RST_EN,
        en_two:     `MIC_RST_EN,
        flags_one:  `MIC_RST_FLAGS_ONE,
        flags_two:  `MIC_RST_FLAGS_TWO,
        wake_flags: `MIC_RST_WAKE_FLAGS,
        rdata:      32'h0000_0000,
        ready:      1'b0,
        slverr:     1'b0,
        cpu:        '0,
        trig:       3'h0
    };

    // Flag bits that hardware can set and software can clear; the rest stand still.
    localparam logic [7:0] FLAGS_ONE_LIVE = 8'hDF;
    localparam logic [7:0] FLAGS_TWO_LIVE = 8'hDE;

    initial
    begin
        if (ADDR_W < 18)
            $error("mic_core: ADDR_W must be at least 18 to reach the register indices");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    mic_state_t                      st_ff;
    mic_state_t                      nxt_st;
    logic [PIN_W-1:0]                pin_raw;
    logic [PIN_W-1:0]                pin_rise;
    logic [PIN_W-1:0]                pin_evt;
    logic                            dec_evt;
    logic [15:0]                     idx;
    logic                            setup;
    logic                            wr_fire;
    logic [`MIC_VEC_COUNT-1:0]       pend;
    logic [7:0]                      set_one;
    logic [7:0]                      set_two;
    logic [7:0]                      set_wake;
    logic [7:0]                      req_edge_rd;

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection

    // Pin order: request pins 4..1, wakeup 7..0, converter, timer F, timer C.
    assign pin_raw = {request_pin_n, wakeup_input_n, converter_trigger_pin,
                      timer_f_event_pin, timer_c_event_pin};

    assign pin_rise = {st_ff.req_edge[4:1], st_ff.wake_edge,
                       st_ff.req_edge[4], st_ff.req_edge[3],
                       st_ff.req_edge[1]};

    mic_edge_sense #(
        .W    (PIN_W),
        .SYNC (1'b1)
    ) u_pins (
        .pclk     (pclk),
        .presetn  (presetn),
        .din      (pin_raw),
        .rise_sel (pin_rise),
        .evt      (pin_evt)
    );

    // The decoder line is on-chip logic on this clock, so it needs no synchroniser.
    mic_edge_sense #(
        .W    (1),
        .SYNC (1'b0)
    ) u_decoder (
        .pclk     (pclk),
        .presetn  (presetn),
        .din      (decoder_line_n),
        .rise_sel (st_ff.req_edge[0]),
        .evt      (dec_evt)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Flag set terms

    always_comb
    begin
        set_one                    = 8'h00;
        set_one[0]                 = dec_evt;
        set_one[4:1]               = pin_evt[14:11];
        set_one[`MIC_B1_SYNC_LINK] = periph_evt.sync_link_done;
        set_one[`MIC_B1_TIMER_A]   = periph_evt.timer_a_ovf;
        set_two                    = 8'h00;
        set_two[`MIC_B2_TIMER_C]   = periph_evt.timer_c_ovf;
        set_two[`MIC_B2_TIMER_FL]  = |periph_evt.timer_fl;
        set_two[`MIC_B2_TIMER_FH]  = |periph_evt.timer_fh;
        set_two[`MIC_B2_TIMER_G]   = |periph_evt.timer_g;
        set_two[`MIC_B2_CONVERTER] = periph_evt.converter_end;
        set_two[`MIC_B2_DIRECT]    = periph_evt.direct_transfer;
        set_wake                   = pin_evt[10:3];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Arbitration

    // Lowest pending vector number wins; unlisted numbers are never pending.
    function automatic logic [4:0] mic_pick(input logic [`MIC_VEC_COUNT-1:0] p);
        logic [4:0] v;
        v = 5'h00;
        for (int i = `MIC_VEC_COUNT - 1; i >= 0; i--)
        begin
            if (p[i])
                v = 5'(i);
        end
        return v;
    endfunction

    always_comb
    begin
        pend = '0;
        for (int i = 0; i < 5; i++)
        begin
            pend[`MIC_VEC_DECODER + i] = st_ff.flags_one[i] & st_ff.en_one[i];
        end
        pend[`MIC_VEC_WAKEUP]     = (|st_ff.wake_flags)
                                    & st_ff.en_one[`MIC_B1_WAKEUP];
        pend[`MIC_VEC_SYNC_LINK]  = st_ff.flags_one[`MIC_B1_SYNC_LINK]
                                    & st_ff.en_one[`MIC_B1_SYNC_LINK];
        pend[`MIC_VEC_TIMER_A]    = st_ff.flags_one[`MIC_B1_TIMER_A]
                                    & st_ff.en_one[`MIC_B1_TIMER_A];
        pend[`MIC_VEC_TIMER_C]    = st_ff.flags_two[`MIC_B2_TIMER_C]
                                    & st_ff.en_two[`MIC_B2_TIMER_C];
        pend[`MIC_VEC_TIMER_FL]   = st_ff.flags_two[`MIC_B2_TIMER_FL]
                                    & st_ff.en_two[`MIC_B2_TIMER_FL];
        pend[`MIC_VEC_TIMER_FH]   = st_ff.flags_two[`MIC_B2_TIMER_FH]
                                    & st_ff.en_two[`MIC_B2_TIMER_FH];
        pend[`MIC_VEC_TIMER_G]    = st_ff.flags_two[`MIC_B2_TIMER_G]
                                    & st_ff.en_two[`MIC_B2_TIMER_G];
        // Serial channels keep their own flags and enables; their causes arrive as levels.
        pend[`MIC_VEC_SERIAL_ONE] = |periph_evt.async_serial_first;
        pend[`MIC_VEC_SERIAL_TWO] = |periph_evt.async_serial_second;
        pend[`MIC_VEC_CONVERTER]  = st_ff.flags_two[`MIC_B2_CONVERTER]
                                    & st_ff.en_two[`MIC_B2_CONVERTER];
        pend[`MIC_VEC_DIRECT]     = st_ff.flags_two[`MIC_B2_DIRECT]
                                    & st_ff.en_two[`MIC_B2_DIRECT];
        if (cpu_global_mask)
            pend = '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    assign idx         = paddr[17:2];
    assign setup       = psel & ~penable;
    assign wr_fire     = psel & penable & st_ff.ready & pwrite & ~st_ff.slverr;
    assign req_edge_rd = {`MIC_REQ_EDGE_FIXED, st_ff.req_edge};

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        nxt_st = st_ff;

        // Answer is prepared in the setup cycle so that bus outputs come from flops.
        nxt_st.ready  = setup;
        nxt_st.slverr = 1'b0;
        nxt_st.rdata  = 32'h0000_0000;
        if (setup)
        begin
            unique case (idx)
                `MIC_IDX_WAKE_EDGE:  nxt_st.rdata[7:0] = st_ff.wake_edge;
                `MIC_IDX_REQ_EDGE:   nxt_st.rdata[7:0] = req_edge_rd;
                `MIC_IDX_EN_ONE:     nxt_st.rdata[7:0] = st_ff.en_one;
                `MIC_IDX_EN_TWO:     nxt_st.rdata[7:0] = st_ff.en_two;
                `MIC_IDX_FLAGS_ONE:  nxt_st.rdata[7:0] = st_ff.flags_one;
                `MIC_IDX_FLAGS_TWO:  nxt_st.rdata[7:0] = st_ff.flags_two;
                `MIC_IDX_WAKE_FLAGS: nxt_st.rdata[7:0] = st_ff.wake_flags;
                default:             nxt_st.slverr     = 1'b1;
            endcase
        end

        // Plain read/write registers.
        if (wr_fire)
        begin
            unique case (idx)
                `MIC_IDX_WAKE_EDGE: nxt_st.wake_edge = pwdata[7:0];
                `MIC_IDX_REQ_EDGE:
                    nxt_st.req_edge = pwdata[`MIC_REQ_EDGE_W-1:0];
                `MIC_IDX_EN_ONE:    nxt_st.en_one = pwdata[7:0];
                `MIC_IDX_EN_TWO:    nxt_st.en_two = pwdata[7:0];
                default:            nxt_st.en_one = st_ff.en_one;
            endcase
        end

        // Flags: a written zero clears a live bit, a written one keeps, and a new event wins.
        nxt_st.flags_one = st_ff.flags_one;
        nxt_st.flags_two = st_ff.flags_two;
        nxt_st.wake_flags = st_ff.wake_flags;
        if (wr_fire && idx == `MIC_IDX_FLAGS_ONE)
            nxt_st.flags_one = st_ff.flags_one & (pwdata[7:0] | ~FLAGS_ONE_LIVE);
        if (wr_fire && idx == `MIC_IDX_FLAGS_TWO)
            nxt_st.flags_two = st_ff.flags_two & (pwdata[7:0] | ~FLAGS_TWO_LIVE);
        if (wr_fire && idx == `MIC_IDX_WAKE_FLAGS)
            nxt_st.wake_flags = st_ff.wake_flags & pwdata[7:0];
        nxt_st.flags_one  = nxt_st.flags_one | (set_one & FLAGS_ONE_LIVE);
        nxt_st.flags_two  = nxt_st.flags_two | (set_two & FLAGS_TWO_LIVE);
        nxt_st.wake_flags = nxt_st.wake_flags | set_wake;

        // Only listed vector numbers can be pending, so reserved slots never appear.
        nxt_st.cpu.valid = |pend;
        nxt_st.cpu.num   = (|pend) ? mic_pick(pend) : 5'h00;
        nxt_st.cpu.addr  = {10'h000, nxt_st.cpu.num, 1'b0};

        // Shared-edge pins are re-offered to their timers and converter as pulses.
        nxt_st.trig = pin_evt[2:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_ff <= RST_ST;
        else
            st_ff <= nxt_st;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign prdata                = st_ff.rdata;
    assign pready                = st_ff.ready;
    assign pslverr               = st_ff.slverr;
    assign cpu_req               = st_ff.cpu;
    assign converter_trigger_evt = st_ff.trig[2];
    assign timer_f_evt           = st_ff.trig[1];
    assign timer_c_evt           = st_ff.trig[0];

endmodule

// File: mic_core_asserts.sv
`include "mic_regs.svh"

module mic_core_asserts
    import mic_pkg::*;
#(
    parameter int ADDR_W = 18
)
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              cpu_global_mask,
    input wire mic_cpu_req_t      cpu_req
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////////////

    // The slave is wait-free, so every setup cycle is answered in the next cycle.
    ack_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ack_single_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    err_with_ack_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    unmapped_err_a: assert property (psel && !penable && !(paddr[ADDR_W-1:2] inside
        {`MIC_IDX_WAKE_EDGE, `MIC_IDX_REQ_EDGE, `MIC_IDX_EN_ONE, `MIC_IDX_EN_TWO,
        `MIC_IDX_FLAGS_ONE, `MIC_IDX_FLAGS_TWO, `MIC_IDX_WAKE_FLAGS}) |=> pslverr)
        else $error("unmapped access accepted");
    rdata_upper_a: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    edge_fixed_a: assert property (pready && !pwrite && !pslverr &&
        paddr[ADDR_W-1:2] == `MIC_IDX_REQ_EDGE |-> prdata[7:5] == 3'h7)
        else $error("edge select top bits not one");
    mask_blocks_a: assert property (cpu_global_mask |=> !cpu_req.valid)
        else $error("request passed while masked");
    vec_reserved_a: assert property (cpu_req.valid |->
        !(cpu_req.addr inside {[16'h0002:16'h0007], [16'h0018:16'h0019]}) &&
        cpu_req.addr == {10'h000, cpu_req.num, 1'b0})
        else $error("bad vector address");
    vec_range_a: assert property (cpu_req.valid |->
        cpu_req.num inside {[5'h04:5'h0B], [5'h0D:5'h14]})
        else $error("vector number out of range");
    rise_unmasked_a: assert property ($rose(cpu_req.valid) |-> !$past(cpu_global_mask))
        else $error("request rose after masked cycle");
endmodule

bind mic_core mic_core_asserts #(.ADDR_W(ADDR_W)) i_mic_core_asserts (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_global_mask(cpu_global_mask), .cpu_req(cpu_req));

// File: mic_edge_sense.sv
// Optional two-stage synchroniser followed by a per-bit edge detector.
module mic_edge_sense
    import mic_pkg::*;
#(
    parameter int W    = 1,
    parameter bit SYNC = 1'b1
)
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] din,
    input  wire logic [W-1:0] rise_sel,
    output logic      [W-1:0] evt
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] prev;
    } mic_es_state_t;

    mic_es_state_t st_ff;
    mic_es_state_t nxt_st;
    logic [W-1:0]  cur;

    initial
    begin
        if (W < 1)
            $error("mic_edge_sense: W must be at least 1");
    end

    assign cur = SYNC ? st_ff.s2 : din;

    always_comb
    begin
        nxt_st      = st_ff;
        nxt_st.s1   = din;
        nxt_st.s2   = st_ff.s1;
        nxt_st.prev = cur;
    end

    // Each bit picks its own edge: one selects rising, zero falling.
    for (genvar i = 0; i < W; i++)
    begin : g_bit
        assign evt[i] = rise_sel[i] ? (cur[i] & ~st_ff.prev[i])
                                    : (~cur[i] & st_ff.prev[i]);
    end

    // Idle level of an active-low pin is high, so a falling edge is not faked at reset.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_ff <= '1;
        else
            st_ff <= nxt_st;
    end

endmodule

// File: mic_pkg.sv
package mic_pkg;

    // Peripheral event lines: 23 causes in all.
    typedef struct packed {
        logic       sync_link_done;
        logic       timer_a_ovf;
        logic       timer_c_ovf;
        logic [1:0] timer_fl;
        logic [1:0] timer_fh;
        logic [1:0] timer_g;
        logic [5:0] async_serial_first;
        logic [5:0] async_serial_second;
        logic       converter_end;
        logic       direct_transfer;
    } mic_periph_evt_t;

    // Request handed to the CPU core.
    typedef struct packed {
        logic        valid;
        logic [4:0]  num;
        logic [15:0] addr;
    } mic_cpu_req_t;

    typedef struct packed {
        logic [4:0]   req_edge;
        logic [7:0]   wake_edge;
        logic [7:0]   en_one;
        logic [7:0]   en_two;
        logic [7:0]   flags_one;
        logic [7:0]   flags_two;
        logic [7:0]   wake_flags;
        logic [31:0]  rdata;
        logic         ready;
        logic         slverr;
        mic_cpu_req_t cpu;
        logic [2:0]   trig;
    } mic_state_t;

endpackage

// File: mic_regs.svh
`ifndef MIC_REGS_SVH
`define MIC_REGS_SVH

// Register indices; the byte address on the bus is four times the index.
`define MIC_IDX_WAKE_EDGE    16'hFF90
`define MIC_IDX_REQ_EDGE     16'hFFF2
`define MIC_IDX_EN_ONE       16'hFFF3
`define MIC_IDX_EN_TWO       16'hFFF4
`define MIC_IDX_FLAGS_ONE    16'hFFF6
`define MIC_IDX_FLAGS_TWO    16'hFFF7
`define MIC_IDX_WAKE_FLAGS   16'hFFF9

// Reset values.
`define MIC_RST_WAKE_EDGE    8'h00
`define MIC_RST_REQ_EDGE     8'hE0
`define MIC_RST_EN           8'h00
`define MIC_RST_FLAGS_ONE    8'h20
`define MIC_RST_FLAGS_TWO    8'h00
`define MIC_RST_WAKE_FLAGS   8'h00

// Request edge-select layout: bits 7 to 5 read as one, bits 4 to 0 stored.
`define MIC_REQ_EDGE_W       5
`define MIC_REQ_EDGE_FIXED   3'h7

// Bit positions shared by the enable and flag registers.
`define MIC_B1_WAKEUP        5
`define MIC_B1_SYNC_LINK     6
`define MIC_B1_TIMER_A       7
`define MIC_B2_TIMER_C       1
`define MIC_B2_TIMER_FL      2
`define MIC_B2_TIMER_FH      3
`define MIC_B2_TIMER_G       4
`define MIC_B2_CONVERTER     6
`define MIC_B2_DIRECT        7

// Vector numbers; the vector address is twice the number.
`define MIC_VEC_DECODER      4
`define MIC_VEC_WAKEUP       9
`define MIC_VEC_SYNC_LINK    10
`define MIC_VEC_TIMER_A      11
`define MIC_VEC_TIMER_C      13
`define MIC_VEC_TIMER_FL     14
`define MIC_VEC_TIMER_FH     15
`define MIC_VEC_TIMER_G      16
`define MIC_VEC_SERIAL_ONE   17
`define MIC_VEC_SERIAL_TWO   18
`define MIC_VEC_CONVERTER    19
`define MIC_VEC_DIRECT       20
`define MIC_VEC_COUNT        21

`endif

// File: mic_src_model.sv
module mic_src_model
    import mic_pkg::*;
(
    input  wire logic      pclk,
    output mic_periph_evt_t periph_evt,
    output logic           cpu_global_mask
);
    timeunit 1ns;
    timeprecision 1ps;

    mic_periph_evt_t strobe;
    logic [5:0]      ser_one;
    logic [5:0]      ser_two;

    // The core leaves reset with its mask bit set, so nothing is taken early.
    initial
    begin
        strobe = '0;
        ser_one = 6'h00;
        ser_two = 6'h00;
        cpu_global_mask = 1'b1;
    end

    // Serial channels hold their causes as levels until software acts on them.
    always_comb
    begin
        periph_evt = strobe;
        periph_evt.async_serial_first = ser_one;
        periph_evt.async_serial_second = ser_two;
    end

    ////////////////////////////////////////////////////////////////////////////////

    task automatic pulse(input mic_periph_evt_t e);
        @(posedge pclk);
        strobe <= e;
        @(posedge pclk);
        strobe <= '0;
    endtask

    task automatic serial(input logic [5:0] a, input logic [5:0] b);
        @(posedge pclk);
        ser_one <= a;
        ser_two <= b;
    endtask

    task automatic set_mask(input logic m);
        @(posedge pclk);
        cpu_global_mask <= m;
    endtask
endmodule

// File: tb_mic_core.sv
`include "mic_regs.svh"

module tb_mic_core
    import mic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic            pclk = 1'b0;
    logic            presetn = 1'b0;
    logic            psel = 1'b0;
    logic            penable = 1'b0;
    logic            pwrite = 1'b0;
    logic [17:0]     paddr = 18'h00000;
    logic [31:0]     pwdata = 32'h00000000;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic [4:0]      irq_n = 5'h1F;
    logic [7:0]      wake_n = 8'hFF;
    logic [2:0]      ext_pin = 3'h7;
    logic [2:0]      ext_evt;
    mic_periph_evt_t periph_evt;
    logic            cpu_global_mask;
    mic_cpu_req_t    cpu_req;
    int              err_total = 0;
    int              compares = 0;
    int              seed = 23551;
    int              w;
    logic [7:0]      rd;
    logic            er;
    logic [15:0]     idx_tab [7] = '{`MIC_IDX_WAKE_EDGE, `MIC_IDX_REQ_EDGE, `MIC_IDX_EN_ONE,
        `MIC_IDX_EN_TWO, `MIC_IDX_FLAGS_ONE, `MIC_IDX_FLAGS_TWO, `MIC_IDX_WAKE_FLAGS};
    logic [4:0]      lad_v [8] = '{5'h0A, 5'h0B, 5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h13, 5'h14};
    int              lad_b [8] = '{6, 7, 1, 2, 3, 4, 6, 7};

    always #12.5 pclk = ~pclk;

    mic_core i_mic_core (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .request_pin_n(irq_n[4:1]), .wakeup_input_n(wake_n), .decoder_line_n(irq_n[0]),
        .converter_trigger_pin(ext_pin[2]), .timer_f_event_pin(ext_pin[1]),
        .timer_c_event_pin(ext_pin[0]), .periph_evt(periph_evt),
        .cpu_global_mask(cpu_global_mask), .cpu_req(cpu_req),
        .converter_trigger_evt(ext_evt[2]), .timer_f_evt(ext_evt[1]),
        .timer_c_evt(ext_evt[0]));

    mic_src_model i_mic_src_model (
        .pclk(pclk), .periph_evt(periph_evt), .cpu_global_mask(cpu_global_mask));

    ////////////////////////////////////////////////////////////////////////////////

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_req(input mic_cpu_req_t got, input mic_cpu_req_t exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t request %h expected %h", $time, got, exp);
        end
    endtask

    function automatic mic_cpu_req_t vec(input logic [4:0] n);
        return '{valid: 1'b1, num: n, addr: {10'h000, n, 1'b0}};
    endfunction

    function automatic logic [7:0] rst_val(input logic [15:0] idx);
        case (idx)
            `MIC_IDX_REQ_EDGE:  return 8'hE0;
            `MIC_IDX_FLAGS_ONE: return 8'h20;
            default:            return 8'h00;
        endcase
    endfunction

    // Outputs are read on the falling edge, where they are settled. The request is
    // released only after the rising edge that sampled pready high.
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(negedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            n++;
            @(negedge pclk);
        end
        if (n == 20)
        begin
            err_total++;
            print_verdict();
        end
        rd = prdata[7:0];
        er = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic expect_vec(input logic [4:0] n);
        int k;
        @(negedge pclk);
        for (k = 0; k < 12 && cpu_req !== vec(n); k++)
            @(negedge pclk);
        chk_req(cpu_req, vec(n));
        if (k == 12)
            print_verdict();
    endtask

    task automatic expect_idle();
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        chk8({7'h00, cpu_req.valid}, 8'h00);
    endtask

    task automatic pin_evt(input logic v);
        logic [2:0] seen;
        seen = 3'h0;
        @(posedge pclk);
        ext_pin <= {3{v}};
        repeat (8)
        begin
            @(negedge pclk);
            seen |= ext_evt;
        end
        chk8({5'h00, seen}, 8'h07);
    endtask

    ////////////////////////////////////////////////////////////////////////////////

    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        foreach (idx_tab[i])
        begin
            apb(1'b0, idx_tab[i], 8'h00);
            chk8(rd, rst_val(idx_tab[i]));
        end
        apb(1'b0, 16'hFFF5, 8'h00);
        chk8({7'h00, er}, 8'h01);
        apb(1'b1, `MIC_IDX_REQ_EDGE, 8'h1F);
        apb(1'b0, `MIC_IDX_REQ_EDGE, 8'h00);
        chk8(rd, 8'hFF);
        apb(1'b1, `MIC_IDX_REQ_EDGE, 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            w = $random(seed);
            apb(1'b1, idx_tab[i % 3 + 1 - (i % 3 == 1 ? 1 : 0) * 0], w[7:0]);
            apb(1'b0, idx_tab[i % 3 + 1 - (i % 3 == 1 ? 1 : 0) * 0], 8'h00);
            chk8(rd, (i % 3 == 0) ? 8'hE0 | w[7:0] : w[7:0]);
        end
        apb(1'b1, `MIC_IDX_REQ_EDGE, 8'h00);
        apb(1'b1, `MIC_IDX_EN_ONE, 8'h80);
        apb(1'b1, `MIC_IDX_EN_TWO, 8'hDE);
        i_mic_src_model.pulse('{sync_link_done: 1'b1, timer_a_ovf: 1'b1, timer_c_ovf: 1'b1,
            timer_fl: 2'h1, timer_fh: 2'h2, timer_g: 2'h3, converter_end: 1'b1,
            direct_transfer: 1'b1, default: '0});
        expect_idle();
        apb(1'b0, `MIC_IDX_FLAGS_TWO, 8'h00);
        chk8(rd, 8'hDE);
        apb(1'b1, `MIC_IDX_FLAGS_TWO, 8'hFF);
        i_mic_src_model.set_mask(1'b0);
        expect_vec(5'h0B);
        apb(1'b1, `MIC_IDX_EN_ONE, 8'hC0);
        for (int i = 0; i < 8; i++)
        begin
            expect_vec(lad_v[i]);
            apb(1'b1, i < 2 ? `MIC_IDX_FLAGS_ONE : `MIC_IDX_FLAGS_TWO, ~(8'h01 << lad_b[i]));
        end
        expect_idle();
        w = {$random(seed)} % 6;
        i_mic_src_model.serial(6'h01 << w, 6'h20);
        expect_vec(5'h11);
        i_mic_src_model.serial(6'h00, 6'h20);
        expect_vec(5'h12);
        i_mic_src_model.serial(6'h00, 6'h00);
        apb(1'b1, `MIC_IDX_EN_ONE, 8'h3F);
        for (int p = 0; p < 5; p++)
        begin
            @(posedge pclk);
            irq_n[p] <= 1'b0;
            expect_vec(5'(4 + p));
            apb(1'b1, `MIC_IDX_FLAGS_ONE, ~(8'h01 << p));
            irq_n[p] <= 1'b1;
            repeat (4) @(posedge pclk);
            apb(1'b0, `MIC_IDX_FLAGS_ONE, 8'h00);
            chk8(rd, 8'h20);
        end
        w = {$random(seed)} % 8;
        @(posedge pclk);
        wake_n[w] <= 1'b0;
        expect_vec(5'h09);
        apb(1'b0, `MIC_IDX_WAKE_FLAGS, 8'h00);
        chk8(rd, 8'h01 << w);
        apb(1'b1, `MIC_IDX_WAKE_EDGE, 8'h01 << w);
        apb(1'b1, `MIC_IDX_WAKE_FLAGS, ~(8'h01 << w));
        expect_idle();
        wake_n[w] <= 1'b1;
        expect_vec(5'h09);
        pin_evt(1'b0);
        apb(1'b1, `MIC_IDX_REQ_EDGE, 8'h1A);
        pin_evt(1'b1);
        print_verdict();
    end
endmodule
